// File: hw/cpts_pkg.sv
`default_nettype none
package cpts_pkg;
   // =====================================================================
   // Sizes
   // =====================================================================
   localparam int NUM_ENTRIES = 8;
   localparam int MAX_DLC = 8;
   localparam int ID_W = 29;
   localparam int PERIOD_W = 16;
   // =====================================================================
   // Timing
   // =====================================================================
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_NS = 1000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
   // =====================================================================
   // Register map, byte offsets within the slave
   // =====================================================================
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [3:0] ENTRY_PAGE = 4'h1;
   localparam logic [3:0] ID_OFS = 4'h0;
   localparam logic [3:0] CFG_OFS = 4'h4;
   localparam logic [3:0] DATA_LO_OFS = 4'h8;
   localparam logic [3:0] DATA_HI_OFS = 4'hc;
   // =====================================================================
   // Field positions and reset values
   // =====================================================================
   localparam int CTRL_EN_BIT = 0;
   localparam int STATUS_BUSY_BIT = 8;
   localparam int STATUS_SYNC_SEEN_BIT = 9;
   localparam int ID_EXT_BIT = 31;
   localparam int CFG_PERIOD_LSB = 0;
   localparam int CFG_DLC_LSB = 16;
   localparam int CFG_START_LSB = 20;
   localparam int CFG_COUNT_LSB = 24;
   localparam int CFG_INCR_BIT = 28;
   localparam int CFG_SYNC_BIT = 29;
   localparam int CFG_ACTIVE_BIT = 31;
   localparam logic [31:0] CFG_RESET = 32'h0118_01f4;
   localparam logic [31:0] ID_RESET = 32'h0000_0000;
   localparam logic [63:0] DATA_RESET = 64'h0000_0000_0000_0000;
   // =====================================================================
   // Sequencer states
   // =====================================================================
   typedef enum logic {CPTS_IDLE, CPTS_SEND} cpts_state_t;
endpackage : cpts_pkg
`default_nettype wire

// File: hw/cpts_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpts_tick_if;
   logic run;
   logic tick;
   modport src (input run, output tick);
   modport dst (output run, input tick);
endinterface : cpts_tick_if
`default_nettype wire

// File: hw/cpts_ms_tick.sv
`timescale 1ns/1ps
`default_nettype none
module cpts_ms_tick #(
   parameter int TICK_CYCLES = cpts_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   cpts_tick_if.src tick_port
);
   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] div_reg;
   logic tick_reg;

   // Held at zero while stopped, so the first millisecond after a start is a full one.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_reg <= '0;
      end else if (!tick_port.run || div_reg == LAST) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= tick_port.run && div_reg == LAST;
      end
   end

   assign tick_port.tick = tick_reg;
endmodule : cpts_ms_tick
`default_nettype wire

// File: hw/cpts_scheduler.sv
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpts_scheduler #(
   parameter int NUM_ENTRIES = cpts_pkg::NUM_ENTRIES,
   parameter int TICK_CYCLES = cpts_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [cpts_pkg::ID_W-1:0] tx_id,
   output logic tx_ext,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   output logic [2:0] tx_entry,
   output logic bus_enabled
);
   localparam int IW = $clog2(NUM_ENTRIES);

   // =====================================================================
   // Storage
   // =====================================================================
   logic enable_reg;
   logic [31:0] id_reg [NUM_ENTRIES];
   logic [31:0] cfg_reg [NUM_ENTRIES];
   logic [63:0] data_reg [NUM_ENTRIES];
   logic [cpts_pkg::PERIOD_W-1:0] count_reg [NUM_ENTRIES];
   logic [NUM_ENTRIES-1:0] due_reg;
   logic sync_seen_reg;
   cpts_pkg::cpts_state_t state_reg;
   logic [IW-1:0] sel_reg;
   logic [cpts_pkg::ID_W-1:0] tx_id_reg;
   logic tx_ext_reg;
   logic [3:0] tx_dlc_reg;
   logic [63:0] tx_data_reg;
   logic wr_pend_reg;
   logic [11:0] wr_addr_reg;
   logic [31:0] hrdata_reg;

   // =====================================================================
   // Decoding and field arithmetic
   // =====================================================================
   function automatic logic entry_hit(input logic [11:0] a);
      return a[11:8] == cpts_pkg::ENTRY_PAGE && int'(a[7:4]) < NUM_ENTRIES;
   endfunction : entry_hit

   function automatic logic [IW-1:0] entry_of(input logic [11:0] a);
      return a[4 +: IW];
   endfunction : entry_of

   // Adds one to the selected byte field with the carry rippling toward higher bytes.
   function automatic logic [63:0] incr_field(input logic [63:0] d, input logic [3:0] start,
                                              input logic [3:0] count);
      logic [63:0] r;
      logic [8:0] s;
      logic c;
      int lo;
      r = d;
      c = 1'b1;
      lo = (start == 4'h0) ? 0 : int'(start) - 1;
      for (int b = 0; b < cpts_pkg::MAX_DLC; b++) begin
         if (b >= lo && b < lo + int'(count)) begin
            s = {1'b0, r[b*8 +: 8]} + {8'h00, c};
            r[b*8 +: 8] = s[7:0];
            c = s[8];
         end
      end
      return r;
   endfunction : incr_field

   function automatic logic [3:0] clamp_dlc(input logic [3:0] d);
      return (int'(d) > cpts_pkg::MAX_DLC) ? 4'(cpts_pkg::MAX_DLC) : d;
   endfunction : clamp_dlc

   function automatic logic [63:0] mask_bytes(input logic [63:0] d, input logic [3:0] dlc);
      logic [63:0] r;
      r = d;
      for (int b = 0; b < cpts_pkg::MAX_DLC; b++) begin
         if (b >= int'(dlc)) begin
            r[b*8 +: 8] = 8'h00;
         end
      end
      return r;
   endfunction : mask_bytes

   // =====================================================================
   // Millisecond tick
   // =====================================================================
   cpts_tick_if tick_bus ();
   assign tick_bus.run = enable_reg;

   cpts_ms_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tick_port(tick_bus.src)
   );

   // =====================================================================
   // AHB-Lite slave
   // =====================================================================
   logic take;
   logic [11:0] a_ofs;
   logic wr_now;
   logic [IW-1:0] wr_idx;
   logic [3:0] wr_sub;
   logic [31:0] rd_word;
   logic [IW-1:0] rd_idx;
   logic [NUM_ENTRIES-1:0] status_due;

   assign take = hsel && htrans[1] && hready;
   assign a_ofs = haddr[11:0];
   assign wr_now = wr_pend_reg && entry_hit(wr_addr_reg);
   assign wr_idx = entry_of(wr_addr_reg);
   assign wr_sub = wr_addr_reg[3:0];
   assign rd_idx = entry_of(a_ofs);
   assign status_due = due_reg;

   always_comb begin
      rd_word = 32'h0000_0000;
      if (a_ofs == cpts_pkg::CTRL_OFS) begin
         rd_word[cpts_pkg::CTRL_EN_BIT] = enable_reg;
      end else if (a_ofs == cpts_pkg::STATUS_OFS) begin
         rd_word[NUM_ENTRIES-1:0] = status_due;
         rd_word[cpts_pkg::STATUS_BUSY_BIT] = state_reg == cpts_pkg::CPTS_SEND;
         rd_word[cpts_pkg::STATUS_SYNC_SEEN_BIT] = sync_seen_reg;
      end else if (entry_hit(a_ofs)) begin
         unique case (a_ofs[3:0])
            cpts_pkg::ID_OFS: rd_word = id_reg[rd_idx];
            cpts_pkg::CFG_OFS: rd_word = cfg_reg[rd_idx];
            cpts_pkg::DATA_LO_OFS: rd_word = data_reg[rd_idx][31:0];
            cpts_pkg::DATA_HI_OFS: rd_word = data_reg[rd_idx][63:32];
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
      end else begin
         wr_pend_reg <= take && hwrite;
         if (take) begin
            wr_addr_reg <= a_ofs;
         end
      end
   end

   // Read data is captured in the address phase so the data phase never waits.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata_reg <= rd_word;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         enable_reg <= 1'b0;
      end else if (wr_pend_reg && wr_addr_reg == cpts_pkg::CTRL_OFS) begin
         enable_reg <= hwdata[cpts_pkg::CTRL_EN_BIT];
      end
   end

   // Identifiers and configuration are only safe to change while the bus is off; the
   // host keeps to that, so no interlock is spent here.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_ENTRIES; i++) begin
            id_reg[i] <= cpts_pkg::ID_RESET;
            cfg_reg[i] <= cpts_pkg::CFG_RESET;
         end
      end else if (wr_now && wr_sub == cpts_pkg::ID_OFS) begin
         id_reg[wr_idx] <= hwdata;
      end else if (wr_now && wr_sub == cpts_pkg::CFG_OFS) begin
         cfg_reg[wr_idx] <= hwdata;
      end
   end

   // =====================================================================
   // Per-entry period counters
   // =====================================================================
   logic any_sync;
   logic realign;
   logic [NUM_ENTRIES-1:0] eligible;
   logic [NUM_ENTRIES-1:0] clear_due;
   logic [IW-1:0] pick;
   logic load;

   always_comb begin
      any_sync = 1'b0;
      for (int i = 0; i < NUM_ENTRIES; i++) begin
         any_sync = any_sync | (cfg_reg[i][cpts_pkg::CFG_ACTIVE_BIT] & cfg_reg[i][cpts_pkg::CFG_SYNC_BIT]);
      end
   end

   assign realign = tx_valid && tx_ready && cfg_reg[sel_reg][cpts_pkg::CFG_SYNC_BIT];

   generate
      for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_entry
         logic active;
         logic is_sync;
         logic expire;
         assign active = cfg_reg[g][cpts_pkg::CFG_ACTIVE_BIT];
         assign is_sync = cfg_reg[g][cpts_pkg::CFG_SYNC_BIT];
         assign expire = tick_bus.tick && active && count_reg[g] <= 16'h0001;
         // Non-sync entries are held back until the sync frame has gone out once.
         assign eligible[g] = due_reg[g] && (is_sync || !any_sync || sync_seen_reg);

         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               count_reg[g] <= '0;
            end else if (!enable_reg) begin
               count_reg[g] <= cfg_reg[g][cpts_pkg::CFG_PERIOD_LSB +: cpts_pkg::PERIOD_W];
            end else if (realign && !is_sync) begin
               count_reg[g] <= cfg_reg[g][cpts_pkg::CFG_PERIOD_LSB +: cpts_pkg::PERIOD_W];
            end else if (expire) begin
               count_reg[g] <= cfg_reg[g][cpts_pkg::CFG_PERIOD_LSB +: cpts_pkg::PERIOD_W];
            end else if (tick_bus.tick && active) begin
               count_reg[g] <= count_reg[g] - 1'b1;
            end
         end

         // A fresh expiry in the cycle the entry is taken wins over the clear.
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               due_reg[g] <= 1'b0;
            end else if (!enable_reg) begin
               due_reg[g] <= 1'b0;
            end else if (expire && !(realign && !is_sync)) begin
               due_reg[g] <= 1'b1;
            end else if (clear_due[g]) begin
               due_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // =====================================================================
   // Sequencer toward the CAN controller
   // =====================================================================
   always_comb begin
      pick = '0;
      for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            pick = IW'(i);
         end
      end
   end

   assign load = enable_reg && state_reg == cpts_pkg::CPTS_IDLE && |eligible;

   always_comb begin
      clear_due = '0;
      if (load) begin
         clear_due[pick] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= cpts_pkg::CPTS_IDLE;
      end else begin
         unique case (state_reg)
            cpts_pkg::CPTS_IDLE: begin
               if (load) begin
                  state_reg <= cpts_pkg::CPTS_SEND;
               end
            end
            cpts_pkg::CPTS_SEND: begin
               if (tx_ready) begin
                  state_reg <= cpts_pkg::CPTS_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_seen_reg <= 1'b0;
      end else if (!enable_reg) begin
         sync_seen_reg <= 1'b0;
      end else if (realign) begin
         sync_seen_reg <= 1'b1;
      end
   end

   // The host value is written at any time; a manual entry is never touched by the
   // sequencer, so a host update lands on the next period unchanged.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_ENTRIES; i++) begin
            data_reg[i] <= cpts_pkg::DATA_RESET;
         end
      end else if (wr_now && wr_sub == cpts_pkg::DATA_LO_OFS) begin
         data_reg[wr_idx][31:0] <= hwdata;
      end else if (wr_now && wr_sub == cpts_pkg::DATA_HI_OFS) begin
         data_reg[wr_idx][63:32] <= hwdata;
      end else if (load && cfg_reg[pick][cpts_pkg::CFG_INCR_BIT]) begin
         data_reg[pick] <= incr_field(data_reg[pick], cfg_reg[pick][cpts_pkg::CFG_START_LSB +: 4],
                                      cfg_reg[pick][cpts_pkg::CFG_COUNT_LSB +: 4]);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_reg <= '0;
         tx_id_reg <= '0;
         tx_ext_reg <= 1'b0;
         tx_dlc_reg <= 4'h0;
         tx_data_reg <= 64'h0000_0000_0000_0000;
      end else if (load) begin
         sel_reg <= pick;
         tx_id_reg <= id_reg[pick][cpts_pkg::ID_W-1:0];
         tx_ext_reg <= id_reg[pick][cpts_pkg::ID_EXT_BIT];
         tx_dlc_reg <= clamp_dlc(cfg_reg[pick][cpts_pkg::CFG_DLC_LSB +: 4]);
         if (cfg_reg[pick][cpts_pkg::CFG_INCR_BIT]) begin
            tx_data_reg <= mask_bytes(incr_field(data_reg[pick], cfg_reg[pick][cpts_pkg::CFG_START_LSB +: 4],
                                                 cfg_reg[pick][cpts_pkg::CFG_COUNT_LSB +: 4]),
                                      clamp_dlc(cfg_reg[pick][cpts_pkg::CFG_DLC_LSB +: 4]));
         end else begin
            tx_data_reg <= mask_bytes(data_reg[pick], clamp_dlc(cfg_reg[pick][cpts_pkg::CFG_DLC_LSB +: 4]));
         end
      end
   end

   // =====================================================================
   // Outputs
   // =====================================================================
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign tx_valid = state_reg == cpts_pkg::CPTS_SEND;
   assign tx_id = tx_id_reg;
   assign tx_ext = tx_ext_reg;
   assign tx_dlc = tx_dlc_reg;
   assign tx_data = tx_data_reg;
   assign tx_entry = 3'(sel_reg);
   assign bus_enabled = enable_reg;
endmodule : cpts_scheduler
`default_nettype wire

// File: bench/cpts_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cpts_properties #(
   parameter int NUM_ENTRIES = 8,
   parameter int TICK_CYCLES = 10
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [28:0] tx_id,
   input wire logic tx_ext,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic [2:0] tx_entry,
   input wire logic bus_enabled
);
   // =====================================================================
   // Helper logic
   // =====================================================================
   logic wr_ctrl_reg;
   logic rd_taken_reg;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ctrl_reg <= 1'b0;
         rd_taken_reg <= 1'b0;
      end else begin
         wr_ctrl_reg <= hsel && htrans[1] && hready && hwrite && haddr[11:0] == 12'h000;
         rd_taken_reg <= hsel && htrans[1] && hready && !hwrite;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // =====================================================================
   // Properties
   // =====================================================================
   chk_offer_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_ext) &&
      $stable(tx_dlc) && $stable(tx_data) && $stable(tx_entry)) else $error("offered frame changed before accept");
   chk_gap_after_send: assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("no idle cycle after send");
   chk_dlc_limit: assert property (tx_valid |-> tx_dlc <= 4'h8) else $error("length code above eight");
   chk_pad_zero: assert property (tx_valid && tx_dlc < 4'h8 |-> (tx_data >> {tx_dlc, 3'b000}) == 64'h0)
      else $error("bytes beyond length not zero");
   chk_send_enabled: assert property ($rose(tx_valid) |-> $past(bus_enabled))
      else $error("frame launched while disabled");
   chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus slave not ready or not okay");
   chk_enable_write: assert property (wr_ctrl_reg |=> bus_enabled == $past(hwdata[0]))
      else $error("enable bit not taken from write");
   chk_rdata_holds: assert property (!rd_taken_reg |-> $stable(hrdata))
      else $error("read data moved without a read");
endmodule : cpts_properties
bind cpts_scheduler cpts_properties #(.NUM_ENTRIES(NUM_ENTRIES), .TICK_CYCLES(TICK_CYCLES)) cpts_properties_i (
   .core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
   .tx_valid, .tx_ready, .tx_id, .tx_ext, .tx_dlc, .tx_data, .tx_entry, .bus_enabled);
`default_nettype wire

// File: bench/cpts_can_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Controller model: accepts each offered frame after stall+1 cycles without ready.
module cpts_can_ctrl (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic tx_valid,
   input wire logic [3:0] stall,
   output logic tx_ready
);
   logic [3:0] wait_reg;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg <= 4'h0;
         tx_ready <= 1'b0;
      end else if (tx_valid && !tx_ready && wait_reg >= stall) begin
         tx_ready <= 1'b1;
         wait_reg <= 4'h0;
      end else begin
         tx_ready <= 1'b0;
         if (tx_valid && !tx_ready) begin
            wait_reg <= wait_reg + 4'h1;
         end
      end
   end
endmodule : cpts_can_ctrl
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int TC = 10;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] stall = 4'h2;
   logic [31:0] r;
   wire logic hreadyout, hresp, tx_valid, tx_ready, tx_ext, bus_enabled;
   wire logic [31:0] hrdata;
   wire logic [28:0] tx_id;
   wire logic [3:0] tx_dlc;
   wire logic [63:0] tx_data;
   wire logic [2:0] tx_entry;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int nf = 0;
   logic [2:0] f_ent[64];
   logic [63:0] f_dat[64];
   logic [28:0] f_id[64];
   logic [3:0] f_dlc[64];
   logic f_ext[64];
   int f_cyc[64];
   cpts_scheduler #(.NUM_ENTRIES(8), .TICK_CYCLES(TC)) cpts_scheduler_i (.core_clk(core_clk), .reset_n(reset_n),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_id(tx_id), .tx_ext(tx_ext), .tx_dlc(tx_dlc), .tx_data(tx_data),
      .tx_entry(tx_entry), .bus_enabled(bus_enabled));
   cpts_can_ctrl cpts_can_ctrl_i (.core_clk(core_clk), .reset_n(reset_n), .tx_valid(tx_valid), .stall(stall),
      .tx_ready(tx_ready));
   always #50 core_clk = ~core_clk;
   // =====================================================================
   // Frame log and hang guard
   // =====================================================================
   always @(posedge core_clk) begin
      cyc++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1 && nf < 64) begin
         f_ent[nf] = tx_entry;
         f_dat[nf] = tx_data;
         f_id[nf] = tx_id;
         f_dlc[nf] = tx_dlc;
         f_ext[nf] = tx_ext;
         f_cyc[nf] = cyc;
         nf++;
      end
      // The guard comes last so that nothing in this process follows the end of the run.
      if (cyc > 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (bad_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One single AHB transfer; the slave may stretch either phase.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk);
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr
   function automatic logic [11:0] ea(input int i, input logic [3:0] ofs);
      return 12'h100 + 12'(16 * i) + {8'h0, ofs};
   endfunction : ea
   function automatic logic [31:0] cfg(input logic [15:0] p, input logic [3:0] dlc, input logic [3:0] st,
      input logic [3:0] cnt, input logic inc, input logic sy);
      return {1'b1, 1'b0, sy, inc, cnt, st, dlc, p};
   endfunction : cfg
   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      int k[3];
      int b;
      int last;
      int e;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      xfer(1'b0, ea(0, 4'h4), 32'h0, r);
      chk("cfg reset", {32'h0, cpts_pkg::CFG_RESET}, {32'h0, r});
      xfer(1'b0, 12'h0f0, 32'h0, r);
      chk("unmapped read", 64'h0, {32'h0, r});
      wr(ea(0, 4'h0), 32'h8000_0038);
      wr(ea(0, 4'h4), cfg(16'h2, 4'h8, 4'h1, 4'h2, 1'b1, 1'b0));
      wr(ea(0, 4'h8), 32'h4422_ffff);
      wr(ea(1, 4'h0), 32'h0000_0345);
      wr(ea(1, 4'h4), cfg(16'h2, 4'h2, 4'h1, 4'h2, 1'b0, 1'b0));
      wr(ea(1, 4'h8), 32'haabb_9977);
      wr(ea(2, 4'h0), 32'h0000_07ff);
      wr(ea(2, 4'h4), cfg(16'h3, 4'h4, 4'h3, 4'h1, 1'b1, 1'b0));
      wr(ea(2, 4'h8), 32'h11ff_3344);
      wr(12'h000, 32'h1);
      while (nf < 8) @(posedge core_clk);
      k = '{0, 0, 0};
      foreach (f_ent[i]) if (i < 8) begin
         e = (i == 2 || i == 7) ? 2 : ((i == 1 || i == 4 || i == 6) ? 1 : 0);
         chk("entry order", 64'(e), {61'h0, f_ent[i]});
         case (f_ent[i])
            3'h0: chk("incr field", 64'h4422_0000 + 64'(k[0]), f_dat[i]);
            3'h1: chk("manual field", 64'h9977, f_dat[i]);
            default: chk("mid field", 64'h1100_3344 + 64'(k[2] << 16), f_dat[i]);
         endcase
         k[f_ent[i]]++;
      end
      chk("ext id", {34'h0, 1'b1, 29'h38}, {34'h0, f_ext[0], f_id[0]});
      chk("std id", {30'h0, 1'b0, 4'h2, 29'h345}, {30'h0, f_ext[1], f_dlc[1], f_id[1]});
      chk("period gap", 64'(2 * TC), 64'(f_cyc[3] - f_cyc[0]));
      chk("period gap 2", 64'(2 * TC), 64'(f_cyc[5] - f_cyc[3]));
      wr(ea(1, 4'h8), 32'h0000_1234);
      b = nf;
      while (nf < b + 6) @(posedge core_clk);
      for (int i = b; i < b + 6; i++) if (f_ent[i] == 3'h1) last = i;
      chk("manual update", 64'h1234, f_dat[last]);
      wr(12'h000, 32'h0);
      repeat (20) @(posedge core_clk);
      stall <= 4'h0;
      wr(ea(7, 4'h0), 32'h0000_0007);
      wr(ea(7, 4'h4), cfg(16'h5, 4'h1, 4'h1, 4'h1, 1'b0, 1'b1));
      b = nf;
      wr(12'h000, 32'h1);
      while (nf < b + 3) @(posedge core_clk);
      chk("sync first", 64'h7, {61'h0, f_ent[b]});
      chk("after sync", 64'h0, {61'h0, f_ent[b + 1]});
      xfer(1'b0, cpts_pkg::CTRL_OFS, 32'h0, r);
      chk("enable readback", 64'h1, {63'h0, r[cpts_pkg::CTRL_EN_BIT]});
      xfer(1'b0, cpts_pkg::STATUS_OFS, 32'h0, r);
      chk("sync seen", 64'h1, {63'h0, r[cpts_pkg::STATUS_SYNC_SEEN_BIT]});
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
